// >>> shared/wdg_pkg.sv
package wdg_pkg;

    // ==================================================================
    // Register map (index, byte address is four times the index)
    localparam logic [15:0] IDX_SERVICE = 16'hffff;   // service / vector
    localparam logic [15:0] IDX_OPT_TWO = 16'h001e;   // option register two
    localparam logic [15:0] IDX_OPT_ONE = 16'h001f;   // option register one
    localparam logic [15:0] IDX_CAUSE   = 16'h0020;   // reset cause register
    localparam logic [19:0] ADDR_SERVICE = 20'({IDX_SERVICE, 2'b00});
    localparam logic [19:0] ADDR_OPT_TWO = 20'({IDX_OPT_TWO, 2'b00});
    localparam logic [19:0] ADDR_OPT_ONE = 20'({IDX_OPT_ONE, 2'b00});
    localparam logic [19:0] ADDR_CAUSE   = 20'({IDX_CAUSE, 2'b00});

    // ==================================================================
    // Option register one fields
    localparam int OPT_WDG_DISABLE  = 0;
    localparam int OPT_STOP_ENABLE  = 1;
    localparam int OPT_SHORT_REC    = 2;
    localparam int OPT_TRIP_SELECT  = 3;
    localparam int OPT_PWR_DISABLE  = 4;
    localparam int OPT_RST_DISABLE  = 5;
    localparam int OPT_STOP_LVI     = 6;
    localparam int OPT_RATE_SELECT  = 7;
    localparam int OPT2_RST_PIN_EN  = 0;   // option register two
    localparam logic [7:0] OPT_ONE_RESET = 8'h00;
    localparam logic [7:0] OPT_TWO_RESET = 8'h00;

    // Reset cause fields
    localparam int CAUSE_WDG = 0;
    localparam int CAUSE_LVI = 1;
    localparam int CAUSE_POR = 2;
    localparam logic [2:0] CAUSE_RESET = 3'h4;   // power-on flag set

    // ==================================================================
    // Cycle counts
    localparam logic [17:0] WDG_SHORT_CYCLES = 18'd8176;
    localparam logic [17:0] WDG_LONG_CYCLES  = 18'd262128;
    localparam logic [5:0]  RST_PIN_CYCLES   = 6'd32;
    localparam logic [12:0] POR_CYCLES       = 13'd4096;
    localparam logic [12:0] REC_SHORT_CYCLES = 13'd32;
    localparam logic [12:0] REC_LONG_CYCLES  = 13'd4096;
    localparam logic [14:0] AWU_SHORT_CYCLES = 15'd512;
    localparam logic [14:0] AWU_LONG_CYCLES  = 15'd16384;

    // ==================================================================
    // Power state
    typedef enum logic [1:0] {
        PW_RUN     = 2'b00,
        PW_STOP    = 2'b01,
        PW_RECOVER = 2'b10
    } pw_state_t;

    // Whole state of the watchdog block
    typedef struct packed {
        logic [11:0] pre;         // prescale counter
        logic [5:0]  wd;          // watchdog counter
        logic [12:0] por_cnt;     // power-on delay count
        logic        por_busy;    // power-on delay running
        logic [5:0]  rst_cnt;     // internal reset length count
        logic        rst_active;  // internal reset in progress
        logic [7:0]  opt_one;     // option register one
        logic [7:0]  opt_two;     // option register two
        logic        one_locked;  // option one already written
        logic        two_locked;  // option two already written
        logic [2:0]  cause;       // reset cause flags
        pw_state_t   pw;          // power state
        logic [12:0] rec_cnt;     // stop recovery count
        logic        rec_long;    // long recovery selected
        logic        vtst_s1;     // test voltage sync stage 1
        logic        vtst_s2;     // test voltage sync stage 2
        logic        lvd_s1;      // low voltage sync stage 1
        logic        lvd_s2;      // low voltage sync stage 2
        logic        pin_s1;      // reset pin sync stage 1
        logic        pin_s2;      // reset pin sync stage 2
        logic        illegal;     // illegal opcode pulse
        logic [31:0] rdata;       // read data
        logic        err;         // unmapped access
    } wdg_state_t;

endpackage : wdg_pkg

// >>> rtl/wdg_core.sv
// The APB register port was decided locally.
`timescale 1ns/1ps
module wdg_core #(
    parameter logic [7:0] RESET_VECTOR_LO = 8'h00   // arbitrary default
) (
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [19:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Core and debug status
    input  wire logic        monitor_mode,
    input  wire logic        test_high_voltage,
    input  wire logic        break_active,
    input  wire logic        break_disables_watchdog,
    input  wire logic        stop_instr,
    input  wire logic        wake_request,
    input  wire logic        low_voltage_detect,
    // Open-drain reset pin
    input  wire logic        rst_pin_i,
    output logic             rst_pin_o,
    output logic             rst_pin_oe,
    // System outputs
    output logic             internal_reset,
    output logic             cpu_clock_run,
    output logic             illegal_opcode,
    output logic             lvi_enable,
    output logic             lvi_trip_5v,
    output logic             awu_short_period,
    output logic      [14:0] awu_period
);
    import wdg_pkg::*;

    // ==================================================================
    // State
    wdg_state_t q;          // registered state
    wdg_state_t n;          // next state

    // ==================================================================
    // Decodes
    logic        setup;     // APB setup phase
    logic        access;    // APB access phase
    logic        wr;        // write takes effect
    logic        hit_srv;   // service register hit
    logic        hit_one;   // option one hit
    logic        hit_two;   // option two hit
    logic        hit_cause; // cause register hit
    logic        cnt_en;    // counters advance
    logic        wd_active; // watchdog allowed to reset
    logic [17:0] limit;     // selected timeout terminal count
    logic        wd_ovf;    // watchdog overflow event
    logic        lvi_rst;   // low-voltage reset event
    logic        pin_rst;   // external pin reset
    logic [12:0] rec_end;   // recovery terminal count

    assign setup     = psel && !penable;
    assign access    = psel && penable;
    assign wr        = access && pwrite;
    assign hit_srv   = paddr == ADDR_SERVICE;
    assign hit_one   = paddr == ADDR_OPT_ONE;
    assign hit_two   = paddr == ADDR_OPT_TWO;
    assign hit_cause = paddr == ADDR_CAUSE;

    // Counting only while running, out of reset and power-on delay
    assign cnt_en = (q.pw == PW_RUN) && !q.rst_active && !q.por_busy;

    // Monitor-mode and break holds, plus the option disable bit
    assign wd_active = !q.opt_one[OPT_WDG_DISABLE]
                    && !(monitor_mode && q.vtst_s2)
                    && !(monitor_mode && break_active
                         && break_disables_watchdog);

    // Rate bit one gives the short timeout
    assign limit = q.opt_one[OPT_RATE_SELECT] ? WDG_SHORT_CYCLES - 18'd1
                                              : WDG_LONG_CYCLES - 18'd1;

    // Overflow of the combined count; reset is the only action
    assign wd_ovf = wd_active && cnt_en && ({q.wd, q.pre} == limit);

    // Monitor resets unless blocked or powered off
    assign lvi_enable = !q.opt_one[OPT_PWR_DISABLE]
                     && ((q.pw == PW_RUN) || q.opt_one[OPT_STOP_LVI]);
    assign lvi_rst = lvi_enable && q.lvd_s2 && !q.opt_one[OPT_RST_DISABLE]
                  && !q.rst_active;
    // The pin reads back our own drive through the synchroniser for two
    // cycles after release, so it is ignored while driving and settling
    assign pin_rst = !q.pin_s2 && !q.rst_active
                  && (q.rst_cnt < RST_PIN_CYCLES || q.rst_cnt > RST_PIN_CYCLES + 6'd1);

    assign rec_end = q.rec_long ? REC_LONG_CYCLES - 13'd1
                                : REC_SHORT_CYCLES - 13'd1;

    // ==================================================================
    // Next-state logic
    always_comb begin
        n = q;
        n.illegal = 1'b0;
        // Two-flop synchronisers for pins
        n.vtst_s1 = test_high_voltage;
        n.vtst_s2 = q.vtst_s1;
        n.lvd_s1  = low_voltage_detect;
        n.lvd_s2  = q.lvd_s1;
        n.pin_s1  = rst_pin_i;
        n.pin_s2  = q.pin_s1;

        // Power-on delay, then clear prescaler
        if (q.por_busy) begin
            n.por_cnt = q.por_cnt + 13'd1;
            if (q.por_cnt == POR_CYCLES - 13'd1) begin
                n.por_busy = 1'b0;
                n.pre      = '0;
            end
        end

        // Prescaler with carry into watchdog counter, only while running
        if (cnt_en) begin
            n.pre = q.pre + 12'd1;
            if (q.pre == 12'hfff) begin
                n.wd = q.wd + 6'd1;
            end
        end

        // Service write clears counter and upper prescale stages
        if (wr && hit_srv) begin
            n.wd       = '0;
            n.pre[11:4] = '0;
        end

        // Power state machine
        unique case (q.pw)
            PW_RUN: begin
                if (stop_instr && !q.rst_active) begin
                    if (q.opt_one[OPT_STOP_ENABLE]) begin
                        n.pw  = PW_STOP;
                        n.pre = '0;
                    end else begin
                        n.illegal = 1'b1;
                    end
                end
            end
            PW_STOP: begin
                if (wake_request) begin
                    n.pw       = PW_RECOVER;
                    n.rec_cnt  = '0;
                    n.rec_long = !q.opt_one[OPT_SHORT_REC];
                end
            end
            PW_RECOVER: begin
                n.rec_cnt = q.rec_cnt + 13'd1;
                if (q.rec_cnt == rec_end) begin
                    n.pw = PW_RUN;
                end
            end
            default: n.pw = PW_RUN;
        endcase

        // Reset length counter
        if (q.rst_active) begin
            n.rst_cnt = q.rst_cnt + 6'd1;
            if (q.rst_cnt == RST_PIN_CYCLES - 6'd1) begin
                n.rst_active = 1'b0;
            end
        end else if (q.rst_cnt >= RST_PIN_CYCLES && q.rst_cnt <= RST_PIN_CYCLES + 6'd1) begin
            n.rst_cnt = q.rst_cnt + 6'd1;                              // Pin settle window
        end

        // APB register writes, once per reset for option registers
        if (wr && hit_one && !q.one_locked) begin
            n.opt_one    = pwdata[7:0];
            n.one_locked = 1'b1;
        end
        if (wr && hit_two && !q.two_locked) begin
            n.opt_two    = pwdata[7:0];
            n.two_locked = 1'b1;
        end
        // Cause flags clear by writing one
        if (wr && hit_cause) begin
            n.cause = q.cause & ~pwdata[2:0];
        end

        // Internal reset: clears counters and non-sticky options
        if (wd_ovf || lvi_rst || pin_rst) begin
            n.rst_active = 1'b1;
            n.rst_cnt    = '0;
            n.pre        = '0;
            n.wd         = '0;
            n.opt_one    = (OPT_ONE_RESET & ~(8'h01 << OPT_TRIP_SELECT))
                         | (q.opt_one & (8'h01 << OPT_TRIP_SELECT));
            n.opt_two    = (OPT_TWO_RESET & ~(8'h01 << OPT2_RST_PIN_EN))
                         | (q.opt_two & (8'h01 << OPT2_RST_PIN_EN));
            n.one_locked = 1'b0;
            n.two_locked = 1'b0;
            n.illegal    = 1'b0;
            n.pw         = PW_RUN;
            // Leaving stop through a low-voltage reset takes long recovery
            if (lvi_rst && (q.pw != PW_RUN)) begin
                n.pw       = PW_RECOVER;
                n.rec_cnt  = '0;
                n.rec_long = 1'b1;
            end
        end
        // Cause set wins over a clear in the same cycle
        if (wd_ovf) begin
            n.cause[CAUSE_WDG] = 1'b1;
        end
        if (lvi_rst) begin
            n.cause[CAUSE_LVI] = 1'b1;
        end

        // Read data captured in setup so it is ready in access
        n.err = 1'b0;
        if (setup) begin
            n.rdata = '0;
            n.err   = !(hit_srv || hit_one || hit_two || hit_cause);
            if (hit_srv) begin
                n.rdata = {24'h0, RESET_VECTOR_LO};
            end else if (hit_one) begin
                n.rdata = {24'h0, q.opt_one};
            end else if (hit_two) begin
                n.rdata = {24'h0, q.opt_two};
            end else if (hit_cause) begin
                n.rdata = {29'h0, q.cause};
            end
        end else if (access) begin
            n.err = q.err;
        end
    end

    // ==================================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_rst_init: begin
                q            <= '0;
                q.por_busy   <= 1'b1;
                q.opt_one    <= OPT_ONE_RESET;
                q.opt_two    <= OPT_TWO_RESET;
                q.cause      <= CAUSE_RESET;
                q.pw         <= PW_RUN;
                q.vtst_s1    <= 1'b0;
                q.pin_s1     <= 1'b1;
                q.pin_s2     <= 1'b1;
            end
        end else begin
            q <= n;
        end
    end

    // ==================================================================
    // Outputs
    assign prdata           = q.rdata;
    assign pready           = 1'b1;
    assign pslverr          = access && q.err;
    assign rst_pin_o        = 1'b0;
    assign rst_pin_oe       = q.rst_active && q.opt_two[OPT2_RST_PIN_EN];
    assign internal_reset   = q.rst_active;
    assign cpu_clock_run    = q.pw == PW_RUN;
    assign illegal_opcode   = q.illegal;
    assign lvi_trip_5v      = q.opt_one[OPT_TRIP_SELECT];
    assign awu_short_period = q.opt_one[OPT_RATE_SELECT];
    assign awu_period       = q.opt_one[OPT_RATE_SELECT] ? AWU_SHORT_CYCLES
                                                         : AWU_LONG_CYCLES;

    // ==================================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Overflow starts an internal reset
    ovf_reset_a: assert property (wd_ovf |=> q.rst_active && q.cause[CAUSE_WDG])
        else $error("overflow did not start reset");

    // Short rate reaches terminal count at 8175
    short_rate_a: assert property (
        (wd_ovf && q.opt_one[OPT_RATE_SELECT]) |-> ({q.wd, q.pre} == 18'd8175))
        else $error("short timeout count wrong");

    // Service write clears upper stages
    service_clr_a: assert property (
        (wr && hit_srv && !q.por_busy) |=> (q.wd == 6'd0 && q.pre[11:4] == 8'h00))
        else $error("service did not clear counters");

    // Service read returns vector byte
    vector_read_a: assert property (
        (setup && !pwrite && hit_srv) |=> (prdata == {24'h0, RESET_VECTOR_LO}))
        else $error("service read wrong");

    // Reset pulse lasts exactly 32 cycles
    rst_len_a: assert property (
        $rose(q.rst_active) |-> q.rst_active [*8] ##24 q.rst_active ##1 !q.rst_active)
        else $error("reset pulse length wrong");

    // Prescaler held clear in power-on delay
    por_hold_a: assert property (q.por_busy |-> q.pre == 12'h000)
        else $error("prescaler ran during power-on");

    // Disabled watchdog never resets
    wd_off_a: assert property (
        (q.opt_one[OPT_WDG_DISABLE] && !q.rst_active) |=> !q.cause[CAUSE_WDG]
            || $past(q.cause[CAUSE_WDG]))
        else $error("disabled watchdog fired");

    // Stop disabled gives illegal opcode
    illegal_op_a: assert property (
        (stop_instr && cpu_clock_run && !q.rst_active
         && !q.opt_one[OPT_STOP_ENABLE] && !wd_ovf && !lvi_rst && !pin_rst)
        |=> illegal_opcode && cpu_clock_run)
        else $error("stop not refused");

    // Locked option register keeps its value
    opt_lock_a: assert property (
        (wr && hit_one && q.one_locked && !wd_ovf && !lvi_rst && !pin_rst)
        |=> q.opt_one == $past(q.opt_one))
        else $error("second option write took effect");

    // Short recovery returns to run in 32 cycles
    short_rec_a: assert property (
        (q.pw == PW_RECOVER && q.rec_cnt == 13'd0 && !q.rec_long)
        |-> ##[1:32] (q.pw == PW_RUN))
        else $error("short recovery too long");

    // Monitor mode with test voltage blocks overflow
    monitor_off_a: assert property (
        (monitor_mode && q.vtst_s2) |-> !wd_ovf)
        else $error("watchdog ran in monitor mode");

    // Break with its disable bit blocks overflow
    break_off_a: assert property (
        (monitor_mode && break_active && break_disables_watchdog) |-> !wd_ovf)
        else $error("watchdog ran during break");

    // Internal reset starts from cleared counters
    int_clear_a: assert property (
        $rose(q.rst_active) |-> (q.pre == 12'h000 && q.wd == 6'h00))
        else $error("reset left counters running");

    // Stop keeps the prescaler cleared
    stop_clear_a: assert property (
        (q.pw == PW_STOP) |-> (q.pre == 12'h000))
        else $error("prescaler ran in stop");

    // Enabled stop instruction enters stop with a cleared prescaler
    stop_enter_a: assert property (
        (stop_instr && q.pw == PW_RUN && !q.rst_active && q.opt_one[OPT_STOP_ENABLE]
         && !wd_ovf && !lvi_rst && !pin_rst)
        |=> (q.pw == PW_STOP && q.pre == 12'h000))
        else $error("stop not entered");

    // Prescaler carry advances the watchdog counter
    carry_step_a: assert property (
        (cnt_en && q.pre == 12'hfff && !wr && !wd_ovf && !lvi_rst && !pin_rst)
        |=> (q.wd == $past(q.wd) + 6'd1))
        else $error("watchdog counter missed a carry");

    // Monitor off in stop unless its stop bit is set
    lvi_stop_a: assert property (
        (q.pw != PW_RUN && !q.opt_one[OPT_STOP_LVI]) |-> !lvi_enable)
        else $error("monitor left on in stop");

    // Reset disable or power disable blocks monitor resets
    lvi_block_a: assert property (
        (q.opt_one[OPT_RST_DISABLE] || q.opt_one[OPT_PWR_DISABLE]) |-> !lvi_rst)
        else $error("blocked monitor reset fired");

    // Low-voltage reset out of stop takes the long recovery
    lvi_long_a: assert property (
        (lvi_rst && q.pw != PW_RUN) |=> (q.pw == PW_RECOVER && q.rec_long))
        else $error("short recovery after monitor reset");

    // Trip select survives internal resets
    trip_keep_a: assert property (
        (wd_ovf || lvi_rst || pin_rst) |=> $stable(q.opt_one[OPT_TRIP_SELECT]))
        else $error("trip select lost on reset");

endmodule : wdg_core

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import wdg_pkg::*;

    // ==========================================================
    // Signals
    localparam logic [7:0] VEC_LO = 8'h5a;   // Arbitrary vector byte
    logic        pclk, presetn, psel, penable, pwrite;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err;
    logic        monitor_mode, test_high_voltage, break_active, break_disables_watchdog;
    logic        stop_instr, wake_request, low_voltage_detect;
    logic        rst_pin_i, rst_pin_o, rst_pin_oe;
    logic        internal_reset, cpu_clock_run, illegal_opcode;
    logic        lvi_enable, lvi_trip_5v, awu_short_period;
    logic [14:0] awu_period;
    int          num_errors, checks_done, n, k;

    // Open-drain pin with pull-up when released
    assign rst_pin_i = rst_pin_oe ? rst_pin_o : 1'b1;

    // ==========================================================
    // Device under test
    wdg_core #(.RESET_VECTOR_LO(VEC_LO)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .monitor_mode(monitor_mode),
        .test_high_voltage(test_high_voltage), .break_active(break_active),
        .break_disables_watchdog(break_disables_watchdog), .stop_instr(stop_instr),
        .wake_request(wake_request), .low_voltage_detect(low_voltage_detect),
        .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
        .internal_reset(internal_reset), .cpu_clock_run(cpu_clock_run),
        .illegal_opcode(illegal_opcode), .lvi_enable(lvi_enable),
        .lvi_trip_5v(lvi_trip_5v), .awu_short_period(awu_short_period),
        .awu_period(awu_period));

    // Clock of 20 ns period
    always #10 pclk = ~pclk;

    // ==========================================================
    // Tasks
    // Compare and count
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; answer taken at the rising edge where pready is high
    task apb(input logic wr, input logic [19:0] a, input logic [31:0] wd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Idle cycles, counting cycles with internal reset high
    task run_cycles(input int c);
        repeat (c) begin
            @(negedge pclk);
            if (internal_reset === 1'b1) n++;
        end
        @(posedge pclk);
    endtask : run_cycles

    // Verdict and end of run
    task stop_test;
        $display("Checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    // ==========================================================
    // Watchdog on the run time
    initial begin
        repeat (70000) @(posedge pclk);
        num_errors++;
        stop_test;
    end

    // ==========================================================
    // Main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 20'h0;
        pwdata = 32'h0;
        monitor_mode = 1'b0;
        test_high_voltage = 1'b0;
        break_active = 1'b0;
        break_disables_watchdog = 1'b0;
        low_voltage_detect = 1'b0;
        stop_instr = 1'b0;
        wake_request = 1'b0;
        repeat (8) @(posedge pclk);
        check(32'(awu_period), 32'(AWU_LONG_CYCLES));
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, vector read, unmapped place
        apb(1'b0, ADDR_CAUSE, 32'h0);
        check(rd, 32'(CAUSE_RESET));
        apb(1'b0, ADDR_SERVICE, 32'h0);
        check(rd, 32'(VEC_LO));
        check({31'h0, err}, 32'h0);
        apb(1'b0, 20'h00100, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b0, ADDR_OPT_ONE, 32'h0);
        check(rd, 32'(OPT_ONE_RESET));
        // Options: short rate, trip 5V, short recovery; second write dropped
        apb(1'b1, ADDR_OPT_TWO, 32'h1);
        apb(1'b1, ADDR_OPT_ONE, 32'h8c);
        apb(1'b1, ADDR_OPT_ONE, 32'h00);
        apb(1'b0, ADDR_OPT_ONE, 32'h0);
        check(rd, 32'h8c);
        check(32'(awu_period), 32'(AWU_SHORT_CYCLES));
        check({31'h0, awu_short_period}, 32'h1);
        check({31'h0, lvi_trip_5v}, 32'h1);
        // Stop instruction while not enabled
        stop_instr <= 1'b1;
        @(posedge pclk);
        stop_instr <= 1'b0;
        @(negedge pclk);
        check({31'h0, illegal_opcode}, 32'h1);
        @(negedge pclk);
        check({31'h0, illegal_opcode}, 32'h0);
        check({31'h0, cpu_clock_run}, 32'h1);
        @(posedge pclk);
        // Past the power-on delay, servicing keeps the reset away
        n = 0;
        run_cycles(4200);
        apb(1'b1, ADDR_SERVICE, 32'hff);
        run_cycles(4000);
        apb(1'b1, ADDR_SERVICE, 32'h00);
        run_cycles(4000);
        apb(1'b1, ADDR_SERVICE, 32'h3c);
        check(32'(n), 32'h0);
        // Unserviced: overflow after the short count
        k = 0;
        do begin
            @(negedge pclk);
            k++;
        end while (internal_reset !== 1'b1 && k < 9000);
        check({31'h0, (k >= int'(WDG_SHORT_CYCLES) - 18 && k <= int'(WDG_SHORT_CYCLES) + 2)},
              32'h1);
        k = 0;
        n = 0;
        while (internal_reset === 1'b1 && k < 100) begin
            if (rst_pin_oe === 1'b1) n++;
            @(negedge pclk);
            k++;
        end
        check(32'(k), 32'(RST_PIN_CYCLES));
        check(32'(n), 32'(RST_PIN_CYCLES));
        check({31'h0, rst_pin_o}, 32'h0);
        @(posedge pclk);
        apb(1'b0, ADDR_CAUSE, 32'h0);
        check(rd & 32'h1, 32'h1);
        apb(1'b0, ADDR_OPT_ONE, 32'h0);
        check(rd, 32'(OPT_ONE_RESET | (8'h01 << OPT_TRIP_SELECT)));
        check({31'h0, lvi_trip_5v}, 32'h1);
        // Disabled watchdog with stop enabled and short recovery
        apb(1'b1, ADDR_OPT_ONE, 32'h87);
        check({31'h0, lvi_enable}, 32'h1);
        n = 0;
        run_cycles(9000);
        check(32'(n), 32'h0);
        // Stop, then wake with short recovery
        stop_instr <= 1'b1;
        @(posedge pclk);
        stop_instr <= 1'b0;
        run_cycles(10);
        check({31'h0, cpu_clock_run}, 32'h0);
        check({31'h0, lvi_enable}, 32'h0);
        wake_request <= 1'b1;
        @(posedge pclk);
        wake_request <= 1'b0;
        k = 0;
        do begin
            @(negedge pclk);
            k++;
        end while (cpu_clock_run !== 1'b1 && k < 5000);
        check({31'h0, (k >= int'(REC_SHORT_CYCLES) && k <= int'(REC_SHORT_CYCLES) + 3)},
              32'h1);
        @(posedge pclk);
        // Second power-on: trip cleared, cause back to power-on only
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({31'h0, lvi_trip_5v}, 32'h0);
        apb(1'b0, ADDR_CAUSE, 32'h0);
        check(rd, 32'(CAUSE_RESET));
        // Monitor mode with test voltage holds the watchdog off
        apb(1'b1, ADDR_OPT_ONE, 32'h80);
        apb(1'b1, ADDR_SERVICE, 32'h0);
        monitor_mode <= 1'b1;
        test_high_voltage <= 1'b1;
        n = 0;
        run_cycles(13000);
        check(32'(n), 32'h0);
        // Break with its disable bit holds it off as well
        test_high_voltage <= 1'b0;
        break_active <= 1'b1;
        break_disables_watchdog <= 1'b1;
        apb(1'b1, ADDR_SERVICE, 32'h0);
        run_cycles(9000);
        check(32'(n), 32'h0);
        stop_test;
    end
endmodule : tb_top
